// [rtl/mbfs_map.vh]
// mbfs_map.vh: constants of the motor bridge fault supervisor.
// assumes a 40 MHz reference clock; counts derive from ns figures, except the wake count.
`ifndef MBFS_MAP_VH
`define MBFS_MAP_VH

// ==========================================================
// timing
`define MBFS_CLK_PERIOD_NS      25
`define MBFS_THERM_MASK_NS      5000
`define MBFS_OC_MASK_NS         2500
`define MBFS_STBY_ENTRY_NS      1000000
`define MBFS_OC_CLEAR_NS        1500000
`define MBFS_STBY_RETURN_NS     30000
`define MBFS_THERM_MASK_CYC (`MBFS_THERM_MASK_NS / `MBFS_CLK_PERIOD_NS)
`define MBFS_OC_MASK_CYC    (`MBFS_OC_MASK_NS / `MBFS_CLK_PERIOD_NS)
`define MBFS_STBY_RET_CYC   (`MBFS_STBY_RETURN_NS / `MBFS_CLK_PERIOD_NS)
`define MBFS_MASK_W             8
`define MBFS_CNT_W              17
`define MBFS_RET_W              11
`define MBFS_WAKE_CYC           11'h004

// ==========================================================
// register byte addresses and reset levels
`define MBFS_ADDR_STATUS        12'h000
`define MBFS_ADDR_EVENT         12'h004
`define MBFS_ADDR_MASK          12'h008
`define MBFS_LIVE_RESET         5'h04

// ==========================================================
// states, one-hot
`define MBFS_ST_STBY            3'h1
`define MBFS_ST_WAKE            3'h2
`define MBFS_ST_RUN             3'h4

`endif

// [rtl/mbfs_mask_filter.v]
// mbfs_mask_filter.v: two-flop synchroniser plus assert mask counter.
// assumes an asynchronous comparator flag; output is the confirmed level.
`include "mbfs_map.vh"

module mbfs_mask_filter #(
  parameter [`MBFS_MASK_W-1:0] MASK_CYC = 8'h01
) (
  input  wire i_ref_clk,
  input  wire i_reset,
  input  wire i_flag,
  output reg  o_confirmed
);

  reg                    sync_a;
  reg                    sync_b;
  reg [`MBFS_MASK_W-1:0] count;

  // ==========================================================
  // synchroniser and mask count
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_a      <= 1'b0;
      sync_b      <= 1'b0;
      count       <= {`MBFS_MASK_W{1'b0}};
      o_confirmed <= 1'b0;
    end else begin
      sync_a <= i_flag;
      sync_b <= sync_a;
      if (!sync_b) begin
        // a short pulse restarts the count, never confirms
        count       <= {`MBFS_MASK_W{1'b0}};
        o_confirmed <= 1'b0;
      end else if (count >= MASK_CYC - 8'h01) begin
        o_confirmed <= 1'b1;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule // mbfs_mask_filter

// [rtl/mbfs_supervisor.v]
// mbfs_supervisor.v: protection supervisor for a one-channel h-bridge.
// assumes asynchronous comparator flags and direction pins, a 40 MHz
// clock, and an apb master for status and interrupt registers.
`include "mbfs_map.vh"

module mbfs_supervisor #(
  parameter [`MBFS_CNT_W-1:0] STBY_ENTRY_CYC = 17'h09C40,
  parameter [`MBFS_CNT_W-1:0] OC_CLEAR_CYC   = 17'h0EA60
) (
  input  wire        i_ref_clk,
  input  wire        i_reset,
  input  wire        i_direction_input_a,
  input  wire        i_direction_input_b,
  input  wire        i_thermal_flag,
  input  wire        i_undervoltage_flag,
  input  wire        i_overcurrent_flag,
  input  wire        i_sense_short_flag,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         o_high_a,
  output reg         o_low_a,
  output reg         o_high_b,
  output reg         o_low_b,
  output reg         o_standby,
  output wire        o_irq
);

  localparam [11:0] ADDR_STATUS = `MBFS_ADDR_STATUS;
  localparam [11:0] ADDR_EVENT  = `MBFS_ADDR_EVENT;
  localparam [11:0] ADDR_MASK   = `MBFS_ADDR_MASK;
  // ns-derived counts are 32-bit integers, cut to the counter widths
  localparam integer RET_CYC_I  = `MBFS_STBY_RET_CYC;
  localparam integer THERM_I    = `MBFS_THERM_MASK_CYC;
  localparam integer OC_I       = `MBFS_OC_MASK_CYC;
  localparam [`MBFS_RET_W-1:0]  RET_CYC    = RET_CYC_I[`MBFS_RET_W-1:0];
  localparam [`MBFS_RET_W-1:0]  WAKE_CYC   = `MBFS_WAKE_CYC;
  localparam [`MBFS_MASK_W-1:0] THERM_MASK = THERM_I[`MBFS_MASK_W-1:0];
  localparam [`MBFS_MASK_W-1:0] OC_MASK    = OC_I[`MBFS_MASK_W-1:0];

  // ==========================================================
  // synchronised inputs and masked flags
  reg  a_s1;
  reg  a_s2;
  reg  b_s1;
  reg  b_s2;
  reg  uv_s1;
  reg  uv_s2;
  reg  sc_s1;
  reg  sc_s2;
  wire therm_ok;
  wire oc_ok;

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      a_s1  <= 1'b0;
      a_s2  <= 1'b0;
      b_s1  <= 1'b0;
      b_s2  <= 1'b0;
      uv_s1 <= 1'b1;
      uv_s2 <= 1'b1;
      sc_s1 <= 1'b0;
      sc_s2 <= 1'b0;
    end else begin
      a_s1  <= i_direction_input_a;
      a_s2  <= a_s1;
      b_s1  <= i_direction_input_b;
      b_s2  <= b_s1;
      uv_s1 <= i_undervoltage_flag;
      uv_s2 <= uv_s1;
      sc_s1 <= i_sense_short_flag;
      sc_s2 <= sc_s1;
    end
  end

  mbfs_mask_filter #(
    .MASK_CYC(THERM_MASK)
  ) u_therm (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_flag     (i_thermal_flag),
    .o_confirmed(therm_ok)
  );

  mbfs_mask_filter #(
    .MASK_CYC(OC_MASK)
  ) u_oc (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_flag     (i_overcurrent_flag),
    .o_confirmed(oc_ok)
  );

  // ==========================================================
  // overcurrent latch and standby sequencing
  reg  [2:0]              state;
  reg  [`MBFS_CNT_W-1:0]  low_count;
  reg  [`MBFS_RET_W-1:0]  wake_count;
  reg                     oc_latched;
  reg                     oc_armed;
  wire                    both_low;
  wire                    any_high;

  assign both_low = !a_s2 && !b_s2;
  assign any_high = a_s2 || b_s2;

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state      <= `MBFS_ST_STBY;
      low_count  <= {`MBFS_CNT_W{1'b0}};
      wake_count <= {`MBFS_RET_W{1'b0}};
      oc_latched <= 1'b0;
      oc_armed   <= 1'b0;
    end else if (uv_s2) begin
      // lockout acts as reset: clears the latch, holds standby
      state      <= `MBFS_ST_STBY;
      oc_latched <= 1'b0;
      oc_armed   <= 1'b0;
      low_count  <= {`MBFS_CNT_W{1'b0}};
      wake_count <= {`MBFS_RET_W{1'b0}};
    end else begin
      if (both_low) begin
        if (low_count != {`MBFS_CNT_W{1'b1}})
          low_count <= low_count + 17'h00001;
      end else begin
        low_count <= {`MBFS_CNT_W{1'b0}};
      end
      if (oc_ok) begin
        oc_latched <= 1'b1;
        oc_armed   <= 1'b0;
      end else if (oc_latched) begin
        if (both_low && low_count >= OC_CLEAR_CYC - 17'h00001)
          oc_armed <= 1'b1;
        if (oc_armed && any_high) begin
          oc_latched <= 1'b0;
          oc_armed   <= 1'b0;
        end
      end
      case (state)
        `MBFS_ST_STBY: begin
          wake_count <= {`MBFS_RET_W{1'b0}};
          // latched fault keeps standby whatever the inputs do
          if (any_high && !oc_latched && !oc_ok)
            state <= `MBFS_ST_WAKE;
        end
        `MBFS_ST_WAKE: begin
          // short settle, well inside the return limit
          if (oc_latched || oc_ok) begin
            state <= `MBFS_ST_STBY;
          end else if (wake_count >= WAKE_CYC ||
                       wake_count >= RET_CYC) begin
            state <= `MBFS_ST_RUN;
          end else begin
            wake_count <= wake_count + 11'h001;
          end
        end
        `MBFS_ST_RUN: begin
          if (oc_ok || oc_latched) begin
            state <= `MBFS_ST_STBY;
          end else if (both_low &&
                       low_count >= STBY_ENTRY_CYC - 17'h00001) begin
            state <= `MBFS_ST_STBY;
          end
        end
        default: state <= `MBFS_ST_STBY;
      endcase
    end
  end

  // ==========================================================
  // output gating: any active fault forces all transistors off
  wire fault_off;
  assign fault_off = therm_ok || uv_s2 || oc_ok || oc_latched ||
                     sc_s2;

  reg next_high_a;
  reg next_low_a;
  reg next_high_b;
  reg next_low_b;

  always @* begin
    next_high_a = 1'b0;
    next_low_a  = 1'b0;
    next_high_b = 1'b0;
    next_low_b  = 1'b0;
    if (!fault_off && state == `MBFS_ST_RUN) begin
      // forward, reverse, brake; both low is stop, all off
      next_high_a = a_s2 && !b_s2;
      next_low_a  = b_s2;
      next_high_b = b_s2 && !a_s2;
      next_low_b  = a_s2;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_high_a  <= 1'b0;
      o_low_a   <= 1'b0;
      o_high_b  <= 1'b0;
      o_low_b   <= 1'b0;
      o_standby <= 1'b1;
    end else begin
      o_standby <= (state != `MBFS_ST_RUN);
      o_high_a  <= next_high_a;
      o_low_a   <= next_low_a;
      o_high_b  <= next_high_b;
      o_low_b   <= next_low_b;
    end
  end

  // ==========================================================
  // apb registers: live status, sticky events, interrupt mask
  wire [4:0] live;
  reg  [4:0] live_q;
  reg  [4:0] events;
  reg  [4:0] mask;
  wire       wr;
  wire       rd;
  wire       mapped;
  wire [4:0] rise;

  assign live    = {oc_latched, sc_s2, uv_s2, oc_ok, therm_ok};
  assign rise    = live & ~live_q;
  assign wr      = psel && penable && pwrite;
  // read data loaded in setup so it stands at the access edge
  assign rd      = psel && !penable && !pwrite;
  assign mapped  = (paddr == ADDR_STATUS) || (paddr == ADDR_EVENT) ||
                   (paddr == ADDR_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign o_irq   = |(events & mask);

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      // lockout is live out of reset, so no false event on release
      live_q <= `MBFS_LIVE_RESET;
      events <= 5'h00;
      mask   <= 5'h00;
      prdata <= 32'h00000000;
    end else begin
      live_q <= live;
      // a new event in the clearing cycle survives the clear
      if (wr && paddr == ADDR_EVENT)
        events <= (events & ~pwdata[4:0]) | rise;
      else
        events <= events | rise;
      if (wr && paddr == ADDR_MASK)
        mask <= pwdata[4:0];
      if (rd) begin
        case (paddr)
          ADDR_STATUS: prdata <= {25'h0000000, state != `MBFS_ST_RUN,
                                  oc_armed, live};
          ADDR_EVENT:  prdata <= {27'h0000000, events};
          ADDR_MASK:   prdata <= {27'h0000000, mask};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // mbfs_supervisor

// [tb/mbfs_host.sv]
// mbfs_host.sv: host controller model driving the two direction pins.
// assumes the bench asks for levels on i_req and waits for o_pins.
module mbfs_host (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_req,
  output logic      [1:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pacing
  logic [7:0] gap;
  // each level stands at least 101 cycles, so a low hold also outlasts the clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pins <= 2'h0;
      gap    <= 8'h00;
    end else if (gap < 8'h64) begin
      gap <= gap + 8'h01;
    end else if (i_req != o_pins) begin
      o_pins <= i_req;
      gap    <= 8'h00;
    end
  end
endmodule // mbfs_host

// [tb/mbfs_supervisor_checker.sv]
// mbfs_supervisor_checker.sv: port assertions for the supervisor.
// assumes a bind onto mbfs_supervisor; flags are async levels.
module mbfs_checker #(
  parameter [16:0] STBY_ENTRY_CYC = 17'h09C40
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_direction_input_a,
  input wire logic i_direction_input_b,
  input wire logic i_thermal_flag,
  input wire logic i_undervoltage_flag,
  input wire logic i_overcurrent_flag,
  input wire logic i_sense_short_flag,
  input wire logic o_high_a,
  input wire logic o_low_a,
  input wire logic o_high_b,
  input wire logic o_low_b,
  input wire logic o_standby
);
  // ==========================================================
  // helpers: run lengths of flags, quiet time of all inputs
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic [7:0]  th_cnt;
  logic [7:0]  oc_cnt;
  logic [16:0] lo_cnt;
  logic [3:0]  qt;
  logic [5:0]  ins_q;
  wire         off = !(o_high_a | o_low_a | o_high_b | o_low_b);
  wire [3:0]   gates = {o_high_a, o_low_a, o_high_b, o_low_b};
  wire [5:0]   ins = {i_direction_input_a, i_direction_input_b,
    i_thermal_flag, i_undervoltage_flag, i_overcurrent_flag,
    i_sense_short_flag};
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      th_cnt <= 8'h00;
      oc_cnt <= 8'h00;
      lo_cnt <= 17'h00000;
      qt     <= 4'h0;
      ins_q  <= 6'h00;
    end else begin
      th_cnt <= i_thermal_flag ? th_cnt + {7'h00, ~&th_cnt} : 8'h00;
      oc_cnt <= i_overcurrent_flag ? oc_cnt + {7'h00, ~&oc_cnt} : 8'h00;
      lo_cnt <= (i_direction_input_a | i_direction_input_b) ? 17'h00000
        : lo_cnt + {16'h0000, ~&lo_cnt};
      qt     <= (ins != ins_q) ? 4'h0 : qt + {3'h0, ~&qt};
      ins_q  <= ins;
    end
  end
  // ==========================================================
  // assertions
  AST_THERM_OFF: assert property (th_cnt >= 8'hD0 |-> off)
    else $error("thermal fault past mask left a gate on");
  AST_OC_OFF: assert property (oc_cnt >= 8'h6C |-> off)
    else $error("overcurrent past mask left a gate on");
  AST_UV_OFF: assert property (i_undervoltage_flag [*4] |=> off)
    else $error("undervoltage left a gate on");
  AST_SHORT_OFF: assert property (i_sense_short_flag [*4] |=> off)
    else $error("sense short left a gate on");
  AST_OC_STBY: assert property (oc_cnt == 8'h6C |-> o_standby [*8])
    else $error("latched overcurrent did not hold standby");
  AST_STBY_OFF: assert property (o_standby |-> off)
    else $error("gate on while in standby");
  AST_STBY_ENTRY: assert property (
    lo_cnt == STBY_ENTRY_CYC + 17'h00008 |-> o_standby)
    else $error("both pins low too long without standby");
  AST_GLITCH: assert property (
    $rose(i_thermal_flag) && qt == 4'hF && !o_standby
    |=> $stable(gates) [*8])
    else $error("short thermal pulse changed the gates");
  cover property (th_cnt == 8'hD0);
  cover property (oc_cnt == 8'h6C);
  cover property ($rose(o_standby));
endmodule // mbfs_checker

// [tb/mbfs_supervisor_tb.sv]
// mbfs_supervisor_tb.sv: directed bench for the fault supervisor.
// assumes shortened standby and clear counts of 40 and 60 cycles.
module mbfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals, models, tasks
  logic        i_ref_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [1:0]  req = 2'h0;
  logic [1:0]  pins;
  logic        th = 1'b0, uv = 1'b0, oc = 1'b0, sh = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, o_high_a, o_low_a, o_high_b, o_low_b;
  logic        o_standby, o_irq;
  int          errors = 0, compares = 0, cyc = 0;
  wire [31:0]  gv = {28'h0000000, o_high_a, o_low_a, o_high_b, o_low_b};
  wire [31:0]  sv = {31'h00000000, o_standby};
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  mbfs_host i_host (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_req(req), .o_pins(pins));
  mbfs_supervisor #(.STBY_ENTRY_CYC(17'h00028), .OC_CLEAR_CYC(17'h0003C))
  i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_direction_input_a(pins[1]), .i_direction_input_b(pins[0]),
    .i_thermal_flag(th), .i_undervoltage_flag(uv),
    .i_overcurrent_flag(oc), .i_sense_short_flag(sh), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_high_a(o_high_a), .o_low_a(o_low_a), .o_high_b(o_high_b),
    .o_low_b(o_low_b), .o_standby(o_standby), .o_irq(o_irq));
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_pins(input logic [1:0] v);
    req <= v;
    do @(posedge i_ref_clk); while (pins !== v);
  endtask
  // data and error taken at the access edge, then one idle edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // scenarios
  logic [1:0] md [3] = '{2'h2, 2'h1, 2'h3};
  logic [3:0] ex [3] = '{4'h9, 4'h6, 4'h5};
  initial begin
    tick(2);
    i_reset <= 1'b0;
    tick(2);
    chk(sv, 32'h1);
    for (int i = 0; i < 3; i++) begin
      set_pins(md[i]);
      tick(40);
      chk(gv, {28'h0000000, ex[i]});
    end
    set_pins(2'h2);
    tick(40);
    th <= 1'b1;
    tick(3);
    th <= 1'b0;
    tick(20);
    chk(gv, 32'h9);
    th <= 1'b1;
    tick(190);
    chk(gv, 32'h9);
    tick(30);
    chk(gv, 32'h0);
    th <= 1'b0;
    tick(30);
    chk(gv, 32'h9);
    apb(12'h004, 1'b0, 32'h0);
    chk(rd & 32'h1F, 32'h01);
    apb(12'h008, 1'b1, 32'h1);
    chk({31'h0, o_irq}, 32'h1);
    apb(12'h004, 1'b1, 32'h1);
    chk({31'h0, o_irq}, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    uv <= 1'b1;
    tick(6);
    chk(gv, 32'h0);
    uv <= 1'b0;
    tick(30);
    chk(gv, 32'h9);
    sh <= 1'b1;
    tick(6);
    chk(gv, 32'h0);
    th <= 1'b1;
    tick(250);
    sh <= 1'b0;
    tick(10);
    chk(gv, 32'h0);
    th <= 1'b0;
    tick(30);
    chk(gv, 32'h9);
    oc <= 1'b1;
    tick(90);
    chk(gv, 32'h9);
    tick(20);
    chk(gv, 32'h0);
    oc <= 1'b0;
    set_pins(2'h1);
    tick(30);
    chk(gv | sv, 32'h1);
    apb(12'h000, 1'b0, 32'h0);
    chk(rd & 32'h50, 32'h50);
    set_pins(2'h0);
    set_pins(2'h2);
    tick(30);
    chk(gv, 32'h9);
    set_pins(2'h0);
    tick(30);
    chk(gv | sv, 32'h0);
    tick(30);
    chk(gv | sv, 32'h1);
    print_verdict();
  end
endmodule // mbfs_supervisor_tb

bind mbfs_supervisor mbfs_checker #(.STBY_ENTRY_CYC(STBY_ENTRY_CYC)) i_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_direction_input_a(i_direction_input_a),
  .i_direction_input_b(i_direction_input_b),
  .i_thermal_flag(i_thermal_flag), .i_undervoltage_flag(i_undervoltage_flag),
  .i_overcurrent_flag(i_overcurrent_flag),
  .i_sense_short_flag(i_sense_short_flag), .o_high_a(o_high_a),
  .o_low_a(o_low_a), .o_high_b(o_high_b), .o_low_b(o_low_b),
  .o_standby(o_standby));
